// ### rtl/ee_cmd_pkg.sv
// Constants shared by both ends of the serial EEPROM command link.
// Assumes one clock, clk, and a synchronous active-low reset, rstn.
package ee_cmd_pkg;

  // ----------------------------------------------------------------
  // Control byte layout
  // ----------------------------------------------------------------
  localparam int CTL_OP = 0;
  localparam int CTL_USA = 1;
  localparam int CTL_NACK = 3;
  localparam int CTL_FERR = 5;
  localparam int CTL_RSV_LO = 6;
  localparam int CTL_RSV_HI = 7;

  // ----------------------------------------------------------------
  // Field order after the command code and optional count
  // ----------------------------------------------------------------
  localparam logic [2:0] F_CTRL = 3'h0;
  localparam logic [2:0] F_ADDR = 3'h1;
  localparam logic [2:0] F_LO = 3'h2;
  localparam logic [2:0] F_HI = 3'h3;
  localparam logic [2:0] F_DATA = 3'h4;
  localparam logic [2:0] WR_FIELDS = 3'h5;
  localparam logic [2:0] RD_FIELDS = 3'h4;
  localparam logic [2:0] RSP_LAST = 3'h5;
  localparam logic [7:0] RSP_COUNT = 8'h05;
  // Command code value; the encoding is arbitrary here.
  localparam logic [7:0] CMD_CODE_EE = 8'h00;

  // ----------------------------------------------------------------
  // Host register map and bits
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_GO = 8'h0C;
  localparam logic [7:0] REG_RESULT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_MASK = 8'h18;
  localparam int CTRL_BLOCK = 8;
  localparam int GO_START = 0;
  localparam int GO_READBACK = 1;
  localparam int RES_BUSY = 16;
  localparam int ST_DONE = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_ERROR = 2;
  localparam int ST_W = 3;
  localparam logic [5:0] CTRL_WMASK = 6'h3F;

endpackage : ee_cmd_pkg

// ### rtl/ee_link_if.sv
// Byte-level link between the SMBus host end and the EEPROM command end.
// Assumes both ends run on the same clock; every signal is a flop output.
interface ee_link_if;
  // Host to device: one byte per cycle while h_valid is high.
  logic h_valid;
  logic h_first;
  logic h_last;
  logic h_block;
  logic [7:0] h_byte;
  logic h_rd;
  // Device to host.
  logic d_ack;
  logic d_claimed;
  logic d_busy;
  logic r_valid;
  logic r_last;
  logic [7:0] r_byte;

  modport dev_end(input h_valid, h_first, h_last, h_block, h_byte, h_rd,
                  output d_ack, d_claimed, d_busy, r_valid, r_last, r_byte);
  modport host_end(output h_valid, h_first, h_last, h_block, h_byte, h_rd,
                   input d_ack, d_claimed, d_busy, r_valid, r_last, r_byte);
endinterface : ee_link_if

// ### rtl/ee_cmd_device.sv
// Device end: decodes EEPROM command frames from the slave port and runs
// one access through the master SMBus engine on the user side.
// Assumes the engine answers each ee_req with exactly one ee_done pulse.
module ee_cmd_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Slave port link
  ee_link_if.dev_end link,
  // Configuration
  input wire logic [7:0] default_eeprom_bus_address,
  // Master SMBus engine
  output logic ee_req,
  output logic ee_read,
  output logic [7:0] ee_bus_addr,
  output logic [15:0] ee_offset,
  output logic [7:0] ee_wdata,
  input wire logic ee_done,
  input wire logic [7:0] ee_rdata,
  input wire logic ee_nack,
  input wire logic ee_framing_err,
  // Bus status register view
  output logic no_ack_error,
  output logic bus_framing_error
);
  import ee_cmd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {D_IDLE, D_ACCESS, D_RESP} dstate_t;

  typedef struct packed {
    dstate_t st;
    logic in_frame;
    logic blk;
    logic seen_cnt;
    logic bad;
    logic [2:0] got;
    logic [7:0] cnt;
    logic [7:0] ctrl;
    logic [7:0] addr;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] data;
    logic nack;
    logic ferr;
    logic ack;
    logic claimed;
    logic busy;
    logic rv;
    logic rl;
    logic [7:0] rb;
    logic [2:0] ri;
    logic req;
    logic rd;
    logic [7:0] bus_addr;
  } dev_t;

  dev_t s;
  dev_t next_s;

  // ----------------------------------------------------------------
  // Reply bytes
  // ----------------------------------------------------------------
  function automatic logic [7:0] ctrl_view(input dev_t v);
    logic [7:0] b;
    b = 8'h00;
    b[CTL_OP] = v.ctrl[CTL_OP];
    b[CTL_USA] = v.ctrl[CTL_USA];
    b[CTL_NACK] = v.nack;
    b[CTL_FERR] = v.ferr;
    return b;
  endfunction : ctrl_view

  function automatic logic [7:0] reply_byte(input dev_t v, input logic [2:0] i);
    logic [7:0] b;
    b = 8'h00;
    if (i == 3'h0) begin
      b = RSP_COUNT;
    end else if (i == 3'h1) begin
      b = ctrl_view(v);
    end else if (i == 3'h2) begin
      b = v.addr;
    end else if (i == 3'h3) begin
      b = v.lo;
    end else if (i == 3'h4) begin
      b = v.hi;
    end else begin
      b = v.data;
    end
    return b;
  endfunction : reply_byte

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic ok;
    logic [2:0] need;
    ok = 1'b0;
    need = WR_FIELDS;
    next_s = s;
    next_s.ack = 1'b0;
    next_s.req = 1'b0;
    next_s.rv = 1'b0;
    next_s.rl = 1'b0;

    // Byte reception; frames arriving while busy are never claimed.
    if (link.h_valid) begin
      if (link.h_first) begin
        next_s.in_frame = 1'b1;
        next_s.blk = link.h_block;
        next_s.seen_cnt = 1'b0;
        next_s.bad = 1'b0;
        next_s.got = 3'h0;
      end else if (!s.in_frame) begin
        next_s.bad = 1'b1;
      end else if (s.blk && !s.seen_cnt) begin
        next_s.cnt = link.h_byte;
        next_s.seen_cnt = 1'b1;
      end else if (s.got == WR_FIELDS) begin
        next_s.bad = 1'b1;
      end else begin
        if (s.got == F_CTRL) begin
          next_s.ctrl = link.h_byte;
        end else if (s.got == F_ADDR) begin
          next_s.addr = link.h_byte;
        end else if (s.got == F_LO) begin
          next_s.lo = link.h_byte;
        end else if (s.got == F_HI) begin
          next_s.hi = link.h_byte;
        end else begin
          next_s.data = link.h_byte;
        end
        next_s.got = s.got + 3'h1;
      end

      if (link.h_last) begin
        next_s.in_frame = 1'b0;
        need = next_s.ctrl[CTL_OP] ? RD_FIELDS : WR_FIELDS;
        ok = !next_s.bad && (next_s.got == need)
             && (next_s.ctrl[CTL_RSV_HI:CTL_RSV_LO] == 2'b00);
        if (next_s.blk && !(next_s.seen_cnt && next_s.cnt == {5'h00, next_s.got})) begin
          ok = 1'b0;
        end
        if (s.st != D_IDLE || s.busy) begin
          ok = 1'b0;
        end
        next_s.ack = 1'b1;
        next_s.claimed = ok;
        if (ok) begin
          // Writing one to a flag clears it.
          if (next_s.ctrl[CTL_NACK]) begin
            next_s.nack = 1'b0;
          end
          if (next_s.ctrl[CTL_FERR]) begin
            next_s.ferr = 1'b0;
          end
          next_s.bus_addr = next_s.ctrl[CTL_USA] ? next_s.addr
                                                 : default_eeprom_bus_address;
          next_s.rd = next_s.ctrl[CTL_OP];
          next_s.req = 1'b1;
          next_s.busy = 1'b1;
          next_s.st = D_ACCESS;
        end
      end
    end

    case (s.st)
      D_IDLE: begin
        if (link.h_rd && !next_s.req) begin
          next_s.st = D_RESP;
          next_s.busy = 1'b1;
          next_s.ri = 3'h0;
          next_s.rv = 1'b1;
          next_s.rb = reply_byte(s, 3'h0);
        end
      end
      D_ACCESS: begin
        if (ee_done) begin
          if (s.rd) begin
            next_s.data = ee_rdata;
          end
          // A set in the same cycle as a clear wins.
          if (ee_nack) begin
            next_s.nack = 1'b1;
          end
          if (ee_framing_err) begin
            next_s.ferr = 1'b1;
          end
          next_s.busy = 1'b0;
          next_s.st = D_IDLE;
        end
      end
      D_RESP: begin
        if (s.ri == RSP_LAST) begin
          next_s.busy = 1'b0;
          next_s.st = D_IDLE;
        end else begin
          next_s.ri = s.ri + 3'h1;
          next_s.rv = 1'b1;
          next_s.rl = (next_s.ri == RSP_LAST);
          next_s.rb = reply_byte(s, next_s.ri);
        end
      end
      default: begin
        next_s.st = D_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.d_ack = s.ack;
  assign link.d_claimed = s.claimed;
  assign link.d_busy = s.busy;
  assign link.r_valid = s.rv;
  assign link.r_last = s.rl;
  assign link.r_byte = s.rb;
  assign ee_req = s.req;
  assign ee_read = s.rd;
  assign ee_bus_addr = s.bus_addr;
  assign ee_offset = {s.hi, s.lo};
  assign ee_wdata = s.data;
  assign no_ack_error = s.nack;
  assign bus_framing_error = s.ferr;

endmodule : ee_cmd_device

// ### rtl/ee_cmd_host.sv
// Host end: an APB register block that builds EEPROM command frames,
// sends them over the link and collects the reply.
// Assumes an APB master on the user side and the device end on the link.
module ee_cmd_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ee_cmd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Link
  ee_link_if.host_end link
);
  import ee_cmd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {H_IDLE, H_PRE, H_SEND, H_ACK, H_WAIT, H_RECV} hstate_t;

  typedef struct packed {
    hstate_t st;
    logic readback;
    logic [5:0] ctrl;
    logic blk;
    logic [7:0] bus_addr;
    logic [15:0] off;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] rctl;
    logic [ST_W-1:0] sts;
    logic [ST_W-1:0] mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] idx;
    logic hv;
    logic hf;
    logic hl;
    logic hb;
    logic [7:0] hbyte;
    logic hrd;
  } host_t;

  host_t s;
  host_t next_s;

  // ----------------------------------------------------------------
  // Frame bytes: code, optional count, control, address, offset, data
  // ----------------------------------------------------------------
  function automatic logic [7:0] tx_byte(input host_t v, input logic [2:0] i);
    logic [7:0] b;
    logic [2:0] f;
    logic [2:0] n;
    b = CMD_CODE_EE;
    n = v.ctrl[CTL_OP] ? RD_FIELDS : WR_FIELDS;
    f = i - (v.blk ? 3'h2 : 3'h1);
    if (i == 3'h0) begin
      b = CMD_CODE_EE;
    end else if (v.blk && i == 3'h1) begin
      b = {5'h00, n};
    end else if (f == F_CTRL) begin
      b = {2'b00, v.ctrl};
    end else if (f == F_ADDR) begin
      b = {v.bus_addr[7:1], 1'b0};
    end else if (f == F_LO) begin
      b = v.off[7:0];
    end else if (f == F_HI) begin
      b = v.off[15:8];
    end else begin
      b = v.wdata;
    end
    return b;
  endfunction : tx_byte

  function automatic logic [2:0] last_idx(input host_t v);
    logic [2:0] n;
    n = v.ctrl[CTL_OP] ? RD_FIELDS : WR_FIELDS;
    return n + (v.blk ? 3'h1 : 3'h0);
  endfunction : last_idx

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wr;
    logic [ST_W-1:0] set;
    logic [ST_W-1:0] clr;
    logic [7:0] a;
    wr = psel && penable && s.pready && pwrite;
    set = '0;
    clr = '0;
    a = paddr;
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.hrd = 1'b0;

    // Register read data is prepared in the setup cycle.
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      if (a == REG_CTRL) begin
        next_s.prdata = {23'h000000, s.blk, 2'b00, s.ctrl};
      end else if (a == REG_TARGET) begin
        next_s.prdata = {8'h00, s.off, s.bus_addr};
      end else if (a == REG_WDATA) begin
        next_s.prdata = {24'h000000, s.wdata};
      end else if (a == REG_GO) begin
        next_s.prdata = 32'h0000_0000;
      end else if (a == REG_RESULT) begin
        next_s.prdata = {15'h0000, s.st != H_IDLE, s.rctl, s.rdata};
      end else if (a == REG_STATUS) begin
        next_s.prdata = {29'h00000000, s.sts};
      end else if (a == REG_MASK) begin
        next_s.prdata = {29'h00000000, s.mask};
      end else begin
        next_s.pslverr = 1'b1;
      end
    end

    if (wr) begin
      if (a == REG_CTRL) begin
        next_s.ctrl = pwdata[5:0] & CTRL_WMASK;
        next_s.blk = pwdata[CTRL_BLOCK];
      end else if (a == REG_TARGET) begin
        next_s.bus_addr = pwdata[7:0];
        next_s.off = pwdata[23:8];
      end else if (a == REG_WDATA) begin
        next_s.wdata = pwdata[7:0];
      end else if (a == REG_GO && s.st == H_IDLE) begin
        if (pwdata[GO_START]) begin
          next_s.st = H_PRE;
          next_s.readback = 1'b0;
        end else if (pwdata[GO_READBACK]) begin
          next_s.st = H_WAIT;
          next_s.readback = 1'b1;
        end
      end else if (a == REG_STATUS) begin
        clr = pwdata[ST_W-1:0];
      end else if (a == REG_MASK) begin
        next_s.mask = pwdata[ST_W-1:0];
      end
    end

    case (s.st)
      H_IDLE: begin
      end
      H_PRE: begin
        if (!link.d_busy) begin
          next_s.st = H_SEND;
          next_s.idx = 3'h0;
          next_s.hv = 1'b1;
          next_s.hf = 1'b1;
          next_s.hl = 1'b0;
          next_s.hb = s.blk;
          next_s.hbyte = tx_byte(s, 3'h0);
        end
      end
      H_SEND: begin
        if (s.hl) begin
          next_s.hv = 1'b0;
          next_s.hl = 1'b0;
          next_s.st = H_ACK;
        end else begin
          next_s.idx = s.idx + 3'h1;
          next_s.hf = 1'b0;
          next_s.hl = (next_s.idx == last_idx(s));
          next_s.hbyte = tx_byte(s, next_s.idx);
        end
      end
      H_ACK: begin
        if (link.d_ack) begin
          if (!link.d_claimed) begin
            set[ST_REFUSED] = 1'b1;
            set[ST_DONE] = 1'b1;
            next_s.st = H_IDLE;
          end else if (s.ctrl[CTL_OP]) begin
            next_s.st = H_WAIT;
          end else begin
            set[ST_DONE] = 1'b1;
            next_s.st = H_IDLE;
          end
        end
      end
      H_WAIT: begin
        if (!link.d_busy) begin
          next_s.hrd = 1'b1;
          next_s.idx = 3'h0;
          next_s.st = H_RECV;
        end
      end
      H_RECV: begin
        if (link.r_valid) begin
          next_s.idx = s.idx + 3'h1;
          if (s.idx == 3'h1) begin
            next_s.rctl = link.r_byte;
          end
          if (link.r_last) begin
            next_s.rdata = link.r_byte;
            set[ST_DONE] = 1'b1;
            set[ST_ERROR] = s.rctl[CTL_NACK] | s.rctl[CTL_FERR];
            next_s.st = H_IDLE;
          end
        end
      end
      default: begin
        next_s.st = H_IDLE;
      end
    endcase

    // Sticky status: a set in the same cycle as a clear wins.
    next_s.sts = (s.sts & ~clr) | set;
    next_s.irq = |(next_s.sts & next_s.mask);
  end

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign link.h_valid = s.hv;
  assign link.h_first = s.hf;
  assign link.h_last = s.hl;
  assign link.h_block = s.hb;
  assign link.h_byte = s.hbyte;
  assign link.h_rd = s.hrd;

endmodule : ee_cmd_host

// ### bench/smbus_eeprom_access_cmd_checker.sv
// Assertions on the link between the host end and the device end.
// Assumes the bench wires it to the joining interface and the engine pins.
module smbus_eeprom_access_cmd_checker
  import ee_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link
  input wire logic h_valid,
  input wire logic h_first,
  input wire logic h_last,
  input wire logic h_block,
  input wire logic [7:0] h_byte,
  input wire logic h_rd,
  input wire logic d_ack,
  input wire logic d_claimed,
  input wire logic d_busy,
  input wire logic r_valid,
  input wire logic r_last,
  input wire logic [7:0] r_byte,
  // Engine
  input wire logic ee_req,
  input wire logic ee_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_ACK_AFTER_LAST: assert property (h_valid && h_last |=> d_ack)
    else $error("frame end not answered");
  AST_ACK_CAUSE: assert property (d_ack |-> $past(h_valid && h_last) ##1 !d_ack)
    else $error("frame answer without a last byte");
  AST_CLAIM_STARTS: assert property (d_ack && d_claimed |-> ee_req && d_busy)
    else $error("claimed frame did not start an access");
  AST_REFUSE_QUIET: assert property (ee_req |-> d_ack && d_claimed)
    else $error("refused frame started an access");
  AST_BUSY_ENDS: assert property (d_busy && ee_done |=> !d_busy)
    else $error("busy held after access done");
  AST_REPLY_SIX: assert property (h_rd |=> r_valid [*6] ##1 !r_valid)
    else $error("reply is not six bytes");
  AST_REPLY_COUNT: assert property (h_rd |=> r_byte == RSP_COUNT && !r_last ##5 r_last)
    else $error("reply count byte or last mark wrong");
  AST_COUNT_BYTE: assert property (h_valid && h_first && h_block |=> h_valid &&
    (h_byte == 8'(WR_FIELDS) || h_byte == 8'(RD_FIELDS)))
    else $error("block count byte wrong");
  AST_CTRL_RSV_BLOCK: assert property (h_valid && h_first && h_block |=> ##1
    h_valid && h_byte[7:6] == 2'b00)
    else $error("control byte top bits set");
  AST_CTRL_RSV_SHORT: assert property (h_valid && h_first && !h_block |=>
    h_valid && h_byte[7:6] == 2'b00)
    else $error("short frame control byte misplaced");
  AST_FRAME_IDLE: assert property (h_valid && h_first |-> !d_busy)
    else $error("frame sent while device busy");
endmodule : smbus_eeprom_access_cmd_checker

// ### bench/tb_smbus_eeprom_access_cmd.sv
// Testbench joining the host end and the device end over the link.
// Assumes a bench model of the EEPROM engine; a second device gets bad frames.
module tb_smbus_eeprom_access_cmd;
  timeunit 1ns;
  timeprecision 1ns;
  import ee_cmd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, dflt, ee_bus_addr, ee_wdata, ee_rdata, got_addr, got_wd;
  logic [31:0] pwdata, prdata;
  logic ee_req, ee_read, ee_done, ee_nack, ee_ferr, no_ack_error, bus_framing_error;
  logic [15:0] ee_offset, got_off;
  logic got_rd, ee_req_b, ee_done_b, mask_on;
  logic [1:0] inj, flags;
  logic [4:0] bcnt;
  int eng_wait, n_errors, check_count;
  logic [7:0] mem [int];
  logic [7:0] wire_q [$];

  ee_link_if link();
  ee_link_if link_b();
  ee_cmd_host i_ee_cmd_host (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link));
  ee_cmd_device i_ee_cmd_device (.clk(clk), .rstn(rstn), .link(link),
    .default_eeprom_bus_address(dflt), .ee_req(ee_req), .ee_read(ee_read),
    .ee_bus_addr(ee_bus_addr), .ee_offset(ee_offset), .ee_wdata(ee_wdata),
    .ee_done(ee_done), .ee_rdata(ee_rdata), .ee_nack(ee_nack), .ee_framing_err(ee_ferr),
    .no_ack_error(no_ack_error), .bus_framing_error(bus_framing_error));
  ee_cmd_device i_ee_cmd_device_b (.clk(clk), .rstn(rstn), .link(link_b),
    .default_eeprom_bus_address(dflt), .ee_req(ee_req_b), .ee_read(), .ee_bus_addr(),
    .ee_offset(), .ee_wdata(), .ee_done(ee_done_b), .ee_rdata(8'h00), .ee_nack(1'b0),
    .ee_framing_err(1'b0), .no_ack_error(), .bus_framing_error());
  smbus_eeprom_access_cmd_checker i_smbus_eeprom_access_cmd_checker (.clk(clk),
    .rstn(rstn), .h_valid(link.h_valid), .h_first(link.h_first), .h_last(link.h_last),
    .h_block(link.h_block), .h_byte(link.h_byte), .h_rd(link.h_rd), .d_ack(link.d_ack),
    .d_claimed(link.d_claimed), .d_busy(link.d_busy), .r_valid(link.r_valid),
    .r_last(link.r_last), .r_byte(link.r_byte), .ee_req(ee_req), .ee_done(ee_done));

  always #50 clk = ~clk;

  function automatic logic [7:0] mem_val(input logic [15:0] off);
    return mem.exists(off) ? mem[off] : off[7:0] ^ off[15:8];
  endfunction : mem_val

  // ----------------------------------------------------------------
  // EEPROM engine models and link monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    ee_done <= 1'b0;
    if (link.h_valid === 1'b1) wire_q.push_back(link.h_byte);
    if (!rstn) eng_wait <= 0;
    else if (ee_req) begin
      got_rd <= ee_read;
      got_addr <= ee_bus_addr;
      got_off <= ee_offset;
      got_wd <= ee_wdata;
      eng_wait <= 1 + $urandom_range(3);
    end else if (eng_wait == 1) begin
      ee_done <= 1'b1;
      ee_nack <= inj[0];
      ee_ferr <= inj[1];
      ee_rdata <= mem_val(ee_offset);
      if (!ee_read && !inj[0]) mem[ee_offset] = ee_wdata;
      eng_wait <= 0;
    end else if (eng_wait != 0) eng_wait <= eng_wait - 1;
  end

  // The second engine stays busy long enough for a frame to overlap it.
  always @(posedge clk) begin
    ee_done_b <= (bcnt == 5'h01);
    if (!rstn) bcnt <= 5'h00;
    else if (ee_req_b) bcnt <= 5'h14;
    else if (bcnt != 5'h00) bcnt <= bcnt - 5'h01;
  end

  // ----------------------------------------------------------------
  // Compare, bus and frame tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    n_errors += pready !== 1'b1;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle();
    logic [31:0] q;
    logic e;
    int n = 0;
    do begin
      apb(1'b0, REG_RESULT, 32'h0, q, e);
      n++;
    end while (q[RES_BUSY] !== 1'b0 && n < 100);
    chk_val("busy end", 32'h0, 32'(q[RES_BUSY]));
  endtask : wait_idle

  task automatic run_op(input logic rd, use_given_bus_address, blk, input logic [1:0] clr, inj_in,
                        input logic [7:0] ba, input logic [15:0] off, input logic [7:0] wd);
    logic [31:0] q;
    logic e;
    logic [7:0] ctl, exp_data;
    logic [7:0] fr [$];
    ctl = {2'b00, clr[1], 1'b0, clr[0], 1'b0, use_given_bus_address, rd};
    exp_data = rd ? mem_val(off) : wd;
    fr = {CMD_CODE_EE, ctl, ba, off[7:0], off[15:8]};
    if (blk) fr.insert(1, rd ? 8'(RD_FIELDS) : 8'(WR_FIELDS));
    if (!rd) fr.push_back(wd);
    inj <= inj_in;
    dflt <= {7'($urandom_range(127)), 1'b0};
    wire_q.delete();
    apb(1'b1, REG_CTRL, {23'h0, blk, ctl}, q, e);
    apb(1'b1, REG_TARGET, {8'h00, off, ba}, q, e);
    apb(1'b1, REG_WDATA, {24'h0, wd}, q, e);
    apb(1'b1, REG_GO, 32'h1, q, e);
    wait_idle();
    chk_val("frame length", 32'(fr.size()), 32'(wire_q.size()));
    foreach (fr[i]) chk_val("frame byte", fr[i], wire_q[i]);
    chk_val("engine op", rd, got_rd);
    chk_val("engine bus address", use_given_bus_address ? ba : dflt, got_addr);
    chk_val("engine offset", off, got_off);
    if (!rd) chk_val("engine write data", wd, got_wd);
    apb(1'b1, REG_GO, 32'h2, q, e);
    wait_idle();
    apb(1'b0, REG_RESULT, 32'h0, q, e);
    flags = (flags & ~clr) | inj_in;
    chk_val("reply data", exp_data, q[7:0]);
    chk_val("reply control", {2'b00, flags[1], 1'b0, flags[0], 1'b0, use_given_bus_address, rd}, q[15:8]);
    chk_val("no ack flag", flags[0], no_ack_error);
    chk_val("framing flag", flags[1], bus_framing_error);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    chk_val("status", {flags != 2'b00, 1'b0, 1'b1}, q[2:0]);
    chk_val("irq raised", mask_on, irq);
    apb(1'b1, REG_STATUS, 32'h7, q, e);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    chk_val("status cleared", 32'h0, q);
    chk_val("irq cleared", 32'h0, irq);
  endtask : run_op

  task automatic send_b(input logic blk, input logic [7:0] fr [$], input logic claim);
    int n = 0;
    foreach (fr[i]) begin
      @(posedge clk);
      link_b.h_valid <= 1'b1;
      link_b.h_first <= (i == 0);
      link_b.h_last <= (i == fr.size() - 1);
      link_b.h_block <= blk;
      link_b.h_byte <= fr[i];
    end
    @(posedge clk);
    link_b.h_valid <= 1'b0;
    link_b.h_last <= 1'b0;
    link_b.h_byte <= ~fr[fr.size() - 1];
    do begin
      @(posedge clk);
      n++;
    end while (link_b.d_ack !== 1'b1 && n < 10);
    chk_val("claim", {claim, 1'b1}, {link_b.d_claimed, link_b.d_ack});
  endtask : send_b

  task automatic idle_b();
    int n = 0;
    while (link_b.d_busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    n_errors += link_b.d_busy !== 1'b0;
  endtask : idle_b

  task print_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    #4000000;
    n_errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic e;
    {psel, penable, pwrite, paddr, pwdata, inj, flags, mask_on} = '0;
    {ee_nack, ee_ferr, ee_rdata} = '0;
    {link_b.h_valid, link_b.h_first, link_b.h_last, link_b.h_block, link_b.h_rd} = '0;
    link_b.h_byte = 8'h00;
    dflt = 8'hB4;
    void'($urandom(9884));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, REG_RESULT, 32'h0, q, e);
    chk_val("reset result", 32'h0, q);
    run_op(1'b0, 1'b1, 1'b1, 2'b00, 2'b00, 8'hFE, 16'hFFFF, 8'h5A);
    run_op(1'b1, 1'b1, 1'b0, 2'b00, 2'b00, 8'h00, 16'hFFFF, 8'h00);
    run_op(1'b1, 1'b0, 1'b1, 2'b00, 2'b01, 8'hA0, 16'h0000, 8'h00);
    run_op(1'b0, 1'b0, 1'b0, 2'b01, 2'b10, 8'hA0, 16'h0000, 8'h3C);
    for (int i = 0; i < 30; i++) begin
      if (i == 10) begin
        apb(1'b1, REG_MASK, 32'h1, q, e);
        mask_on = 1'b1;
      end
      run_op(1'($urandom_range(1)), 1'($urandom_range(1)), 1'($urandom_range(1)),
             2'($urandom_range(3)), {$urandom_range(5) == 0, $urandom_range(5) == 0},
             {7'($urandom_range(127)), 1'b0},
             {8'($urandom_range(1) * 255), 8'($urandom_range(7))}, 8'($urandom));
    end
    apb(1'b0, 8'h1C, 32'h0, q, e);
    chk_val("unmapped read", 32'h1, 32'(e));
    chk_val("unmapped data", 32'h0, q);
    send_b(1'b1, {8'h00, 8'h05, 8'h00, 8'hA0, 8'h10, 8'h00, 8'h77}, 1'b1);
    send_b(1'b1, {8'h00, 8'h05, 8'h00, 8'hA0, 8'h11, 8'h00, 8'h78}, 1'b0);
    idle_b();
    send_b(1'b0, {8'h00, 8'h01, 8'hA0, 8'h10, 8'h00}, 1'b1);
    idle_b();
    send_b(1'b0, {8'h00, 8'h01, 8'hA0, 8'h10}, 1'b0);
    send_b(1'b0, {8'h00, 8'h40, 8'hA0, 8'h10, 8'h00, 8'h55}, 1'b0);
    send_b(1'b1, {8'h00, 8'h04, 8'h00, 8'hA0, 8'h10, 8'h00, 8'h55}, 1'b0);
    print_verdict();
  end
endmodule : tb_smbus_eeprom_access_cmd
